// ### swr_pkg.sv
/*
 * swr_pkg: constants for the supervisor watchdog reset block.
 * assumes a 100 MHz system clock; all timing is in timebase ticks, internal oscillator or external.
 */
package swr_pkg;
    // ==========================================================
    // clock and internal oscillator
    // ==========================================================
    localparam int  CLK_HZ          = 100_000_000;
    localparam int  OSC_HZ_X100     = 1_024_000;   // 10.24 kHz times 100
    localparam int  OSC_DIV         = (CLK_HZ / OSC_HZ_X100) * 100
                                      + ((CLK_HZ % OSC_HZ_X100) * 100)
                                        / OSC_HZ_X100;
    // ==========================================================
    // durations in ticks (internal: 10.24 kHz, 1 tick = 97.66 us)
    // ==========================================================
    localparam int  INT_SHORT_MS    = 100;
    localparam int  INT_LONG_MS     = 1600;
    localparam int  INT_RST_MS      = 50;
    localparam int  INT_SHORT_TICKS = INT_SHORT_MS * 1024 / 100;
    localparam int  INT_LONG_TICKS  = INT_LONG_MS * 1024 / 100;
    localparam int  INT_RST_TICKS   = INT_RST_MS * 1024 / 100;
    localparam int  EXT_SHORT_TICKS = 1024;
    localparam int  EXT_LONG_TICKS  = 4096;
    localparam int  EXT_RST_TICKS   = 512;
    localparam int  TICK_W          = 15;
    // ==========================================================
    // supervisor states
    // ==========================================================
    typedef enum logic [1:0] {
        SWR_RESET,
        SWR_WAIT_FIRST,
        SWR_NORMAL
    } swr_state_t;
endpackage : swr_pkg

// ### swr_sync.sv
/*
 * swr_sync: two-flop synchroniser for one asynchronous pin level.
 * assumes the pin is quasi-static relative to clk.
 */
`timescale 1ns/1ps
module swr_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,      // system clock
    input  wire logic sys_rst,  // synchronous reset, active high
    input  wire logic pinIn,    // asynchronous level
    output logic      syncOut   // synchronised level
);
    logic stage1_r;
    logic stage1_nxt;
    logic stage2_nxt;

    always_comb begin
        stage1_nxt = sys_rst ? INIT : pinIn;
        stage2_nxt = sys_rst ? INIT : stage1_r;
    end

    always_ff @(posedge clk) begin
        stage1_r <= stage1_nxt;
        syncOut  <= stage2_nxt;
    end
endmodule : swr_sync

// ### swr_tick.sv
/*
 * swr_tick: timebase tick generator.
 * internal mode divides clk to 10.24 kHz; external mode ticks on each
 * rising edge of the already synchronised external timebase.
 */
`timescale 1ns/1ps
module swr_tick
    import swr_pkg::*;
#(
    parameter int DIV = swr_pkg::OSC_DIV
) (
    input  wire logic clk,        // system clock
    input  wire logic sys_rst,    // synchronous reset, active high
    input  wire logic useInternal,// internal oscillator enabled
    input  wire logic extLevel,   // synchronised external timebase
    output logic      tick        // one-cycle tick pulse
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] divCnt_r;
    logic [CW-1:0] divCnt_nxt;
    logic          extPrev_r;
    logic          tick_nxt;

    always_comb begin
        divCnt_nxt = divCnt_r + 1'b1;
        tick_nxt   = 1'b0;
        if (divCnt_r == CW'(DIV - 1)) begin
            divCnt_nxt = '0;
            tick_nxt   = useInternal;
        end
        if (!useInternal) begin
            tick_nxt = extLevel & ~extPrev_r;
        end
        if (sys_rst) begin
            divCnt_nxt = '0;
            tick_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        divCnt_r  <= divCnt_nxt;
        extPrev_r <= sys_rst ? 1'b0 : extLevel;
        tick      <= tick_nxt;
    end
endmodule : swr_tick

// ### swr_watchdog.sv
/*
 * swr_watchdog: supervisor reset generator, watchdog and chip-select gate.
 * assumes supply_sense_in comes from a threshold comparator (high = low
 * supply) and the three-level toggle pin is split by an external
 * window detector into a level and a float flag; all pins asynchronous.
 */
// How it works
// - reset output low whenever supply-low indication is active
// - reset held a reset-active period after supply-low clears
// - active-high reset is always the complement of active-low reset
// - missed toggle within timeout gives reset pulse of reset-active length
// - long timeout applies directly after any reset
// - watchdog counter restarts when reset ends
// - short timeout takes effect only after first toggle after reset
// - every toggle edge, rising or falling, restarts the timeout
// - constant toggle input gives a reset after every long timeout
// - floating or mid-supply toggle input disables the watchdog
// - external source: 1024 normal, 4096 after reset, 512 reset ticks
// - internal, timebase low: 100 ms, 1.6 s after reset, 50 ms reset
// - internal, timebase high or floating: 1.6 s always, 50 ms reset
// - select high uses internal oscillator, low uses external timebase
// - internal oscillator runs at 10.24 kHz
// - status low on timeout, stays low until next toggle edge
// - status forced high while supply-low is active
// - gated chip-select follows input while supply is good
// - gated chip-select forced high while supply is low
// - supply-low status output follows the supply-low indication
`timescale 1ns/1ps
module swr_watchdog
    import swr_pkg::*;
#(
    parameter int DIV = swr_pkg::OSC_DIV
) (
    input  wire logic clk,                  // system clock, 100 MHz
    input  wire logic sys_rst,              // synchronous reset, high
    input  wire logic supply_sense_in,      // high while supply is low
    input  wire logic watchdog_toggle_in,   // toggle level from cpu
    input  wire logic watchdogFloat,        // toggle pin floating/mid
    input  wire logic timebase_source_sel,  // high = internal oscillator
    input  wire logic timebase_in,          // ext clock or speed select
    input  wire logic chipSelInN,           // chip select in, low active
    output logic      resetOutN,            // reset, active low
    output logic      resetOut,             // reset, active high
    output logic      watchdog_timeout_n,   // watchdog status, low active
    output logic      supplyLowN,           // low while supply is low
    output logic      chipSelOutN           // gated chip select
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic supplyLow;
    logic wdLevel;
    logic wdFloat;
    logic oscSel;
    logic tbLevel;
    logic csInN;

    swr_sync #(.INIT(1'b1)) uSupply (.clk(clk), .sys_rst(sys_rst),
        .pinIn(supply_sense_in), .syncOut(supplyLow));
    swr_sync #(.INIT(1'b0)) uWdLvl (.clk(clk), .sys_rst(sys_rst),
        .pinIn(watchdog_toggle_in), .syncOut(wdLevel));
    swr_sync #(.INIT(1'b1)) uWdFlt (.clk(clk), .sys_rst(sys_rst),
        .pinIn(watchdogFloat), .syncOut(wdFloat));
    swr_sync #(.INIT(1'b1)) uOscSel (.clk(clk), .sys_rst(sys_rst),
        .pinIn(timebase_source_sel), .syncOut(oscSel));
    swr_sync #(.INIT(1'b1)) uTb (.clk(clk), .sys_rst(sys_rst),
        .pinIn(timebase_in), .syncOut(tbLevel));
    swr_sync #(.INIT(1'b1)) uCs (.clk(clk), .sys_rst(sys_rst),
        .pinIn(chipSelInN), .syncOut(csInN));

    // ==========================================================
    // timebase
    // ==========================================================
    logic tick;

    swr_tick #(.DIV(DIV)) uTick (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .useInternal(oscSel),
        .extLevel   (tbLevel),
        .tick       (tick)
    );

    // ==========================================================
    // period selection
    // ==========================================================
    logic [TICK_W-1:0] shortLimit;
    logic [TICK_W-1:0] longLimit;
    logic [TICK_W-1:0] rstLimit;

    always_comb begin
        if (!oscSel) begin
            shortLimit = TICK_W'(EXT_SHORT_TICKS);
            longLimit  = TICK_W'(EXT_LONG_TICKS);
            rstLimit   = TICK_W'(EXT_RST_TICKS);
        end else if (!tbLevel) begin
            shortLimit = TICK_W'(INT_SHORT_TICKS);
            longLimit  = TICK_W'(INT_LONG_TICKS);
            rstLimit   = TICK_W'(INT_RST_TICKS);
        end else begin
            shortLimit = TICK_W'(INT_LONG_TICKS);
            longLimit  = TICK_W'(INT_LONG_TICKS);
            rstLimit   = TICK_W'(INT_RST_TICKS);
        end
    end

    // ==========================================================
    // supervisor state machine
    // ==========================================================
    swr_state_t        state_r;
    swr_state_t        state_nxt;
    logic [TICK_W-1:0] cnt_r;
    logic [TICK_W-1:0] cnt_nxt;
    logic              wdPrev_r;
    logic              wdo_r;
    logic              wdo_nxt;
    logic              toggled;
    logic [TICK_W-1:0] wdLimit;
    logic              cntDone;

    // a float flag masks edges too, so entering float is never a toggle
    assign toggled = (wdLevel != wdPrev_r) && !wdFloat;
    assign wdLimit = (state_r == SWR_NORMAL) ? shortLimit : longLimit;
    assign cntDone = tick && (cnt_r >= wdLimit - 1'b1);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wdo_nxt   = wdo_r;
        if (toggled) begin
            wdo_nxt = 1'b1;
        end
        unique case (state_r)
            SWR_RESET: begin
                if (supplyLow) begin
                    cnt_nxt = '0;
                end else if (tick) begin
                    if (cnt_r >= rstLimit - 1'b1) begin
                        state_nxt = SWR_WAIT_FIRST;
                        cnt_nxt   = '0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            SWR_WAIT_FIRST, SWR_NORMAL: begin
                if (supplyLow) begin
                    state_nxt = SWR_RESET;
                    cnt_nxt   = '0;
                end else if (wdFloat) begin
                    cnt_nxt = '0;
                end else if (toggled) begin
                    state_nxt = SWR_NORMAL;
                    cnt_nxt   = '0;
                end else if (cntDone) begin
                    // long period after reset, repeating while stuck
                    state_nxt = SWR_RESET;
                    cnt_nxt   = '0;
                    wdo_nxt   = 1'b0;
                end else if (tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = SWR_RESET;
                cnt_nxt   = '0;
            end
        endcase
        if (supplyLow) begin
            wdo_nxt = 1'b1;
        end
        if (sys_rst) begin
            state_nxt = SWR_RESET;
            cnt_nxt   = '0;
            wdo_nxt   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        state_r  <= state_nxt;
        cnt_r    <= cnt_nxt;
        wdPrev_r <= sys_rst ? 1'b0 : wdLevel;
        wdo_r    <= wdo_nxt;
    end

    // ==========================================================
    // output registers
    // ==========================================================
    logic resetN_nxt;
    logic csOut_nxt;

    always_comb begin
        resetN_nxt = (state_nxt != SWR_RESET);
        csOut_nxt  = supplyLow ? 1'b1 : csInN;
        if (sys_rst) begin
            resetN_nxt = 1'b0;
            csOut_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        resetOutN          <= resetN_nxt;
        resetOut           <= ~resetN_nxt;
        watchdog_timeout_n <= wdo_nxt;
        supplyLowN         <= sys_rst ? 1'b1 : ~supplyLow;
        chipSelOutN        <= csOut_nxt;
    end

    // ==========================================================
    // assertions
    // ==========================================================
    sequence sLowSupply;
        supplyLow;
    endsequence

    a_reset_complement: assert property (@(posedge clk)
        disable iff (sys_rst) resetOut == !resetOutN)
        else $error("reset outputs not complementary");

    a_low_holds_reset: assert property (@(posedge clk)
        disable iff (sys_rst) sLowSupply |=> !resetOutN)
        else $error("reset released during low supply");

    a_cs_blocked: assert property (@(posedge clk)
        disable iff (sys_rst) sLowSupply |=> chipSelOutN)
        else $error("chip select passed during low supply");

    a_cs_follows: assert property (@(posedge clk)
        disable iff (sys_rst) !supplyLow |=> chipSelOutN == $past(csInN))
        else $error("chip select not following input");

    a_wdo_high_low: assert property (@(posedge clk)
        disable iff (sys_rst) sLowSupply |=> watchdog_timeout_n)
        else $error("status not forced high on low supply");

    a_lowline_out: assert property (@(posedge clk)
        disable iff (sys_rst)
        supplyLowN == ($past(sys_rst) || !$past(supplyLow)))
        else $error("supply status wrong");

    a_float_no_reset: assert property (@(posedge clk)
        disable iff (sys_rst)
        (wdFloat && !supplyLow && state_r != SWR_RESET)
            |=> state_r != SWR_RESET)
        else $error("watchdog fired while floating");

    a_toggle_clears: assert property (@(posedge clk)
        disable iff (sys_rst)
        (toggled && !supplyLow && state_r != SWR_RESET) |=> cnt_r == '0)
        else $error("toggle did not restart count");

    a_timeout_wdo: assert property (@(posedge clk)
        disable iff (sys_rst)
        (cntDone && !wdFloat && !toggled && !supplyLow &&
         state_r != SWR_RESET) |=> !watchdog_timeout_n && !resetOutN)
        else $error("timeout without status and reset");

    // ==========================================================
    // assertions on the watchdog sequence
    // ==========================================================
    sequence sResetEnds;
        $rose(resetOutN);
    endsequence

    sequence sServiced;
        toggled && !supplyLow;
    endsequence

    a_reset_length: assert property (@(posedge clk)
        disable iff (sys_rst)
        sResetEnds |-> $past(tick)
            && ($past(cnt_r) >= $past(rstLimit) - 1'b1))
        else $error("reset released before its period ended");

    a_restart_on_end: assert property (@(posedge clk)
        disable iff (sys_rst)
        sResetEnds |-> state_r == SWR_WAIT_FIRST && cnt_r == '0)
        else $error("watchdog not restarted with long period");

    a_first_toggle: assert property (@(posedge clk)
        disable iff (sys_rst)
        (sServiced ##0 (state_r == SWR_WAIT_FIRST)) |=> state_r == SWR_NORMAL)
        else $error("short period not selected by first toggle");

    a_status_set: assert property (@(posedge clk)
        disable iff (sys_rst) sServiced |=> watchdog_timeout_n)
        else $error("status not set high by toggle");

    a_status_stays: assert property (@(posedge clk)
        disable iff (sys_rst)
        (!watchdog_timeout_n && !toggled && !supplyLow)
            |=> !watchdog_timeout_n)
        else $error("status left low state without a toggle");

    a_float_count: assert property (@(posedge clk)
        disable iff (sys_rst)
        (wdFloat && !supplyLow && state_r != SWR_RESET) |=> cnt_r == '0)
        else $error("count ran while watchdog disabled");

    a_slow_select: assert property (@(posedge clk)
        disable iff (sys_rst)
        (oscSel && tbLevel) |-> shortLimit == longLimit)
        else $error("short period active with slow select");

    a_start_state: assert property (@(posedge clk)
        sys_rst |=> !resetOutN && resetOut && watchdog_timeout_n
            && supplyLowN && chipSelOutN)
        else $error("outputs not in reset state");
endmodule : swr_watchdog

// ### swr_cpu_model.sv
/*
 * swr_cpu_model: processor that services the supervisor watchdog.
 * assumes resetOutN comes from the supervisor; gap counts clk cycles.
 */
`timescale 1ns/1ps
module swr_cpu_model (
    input  wire logic        clk,       // system clock
    input  wire logic        resetOutN, // reset from the supervisor
    input  wire logic        enable,    // keep servicing
    input  wire logic [15:0] gap,       // cycles between toggles
    input  wire logic        floatReq,  // release the toggle pin
    output logic             toggleOut, // toggle pin level
    output logic             floatOut   // pin seen as floating
);
    logic [15:0] cnt = 16'h0;
    initial toggleOut = 1'b0;
    assign floatOut = floatReq;
    // ==========================================================
    // toggle generator
    // ==========================================================
    always @(posedge clk) begin
        if (!resetOutN) begin
            cnt <= 16'h0;
        end else if (floatReq) begin
            // a released pin settles at its pull-up level; a wandering
            // level would service the watchdog and hide a missed disable
            toggleOut <= 1'b1;
        end else if (enable && cnt >= gap) begin
            cnt       <= 16'h0;
            toggleOut <= ~toggleOut;
        end else begin
            cnt <= enable ? cnt + 16'h1 : 16'h0;
        end
    end
endmodule : swr_cpu_model

// ### test_supervisor_watchdog_reset.sv
/*
 * test_supervisor_watchdog_reset: self-checking bench for swr_watchdog.
 * assumes swr_cpu_model as processor; external timebase period 5 clk.
 */
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("mismatch %s expected %0d seen %0d", what, exp, got); \
        end \
    end
module test_supervisor_watchdog_reset;
    import swr_pkg::*;
    localparam int DIVS = 4;
    localparam int EXTP = 5;
    logic        clk = 0, sys_rst = 1, supply_sense_in = 0, chipSelInN = 1;
    logic        timebase_source_sel = 0, timebase_in = 0, extRun = 1;
    logic        enable = 0, floatReq = 0, prevTgl = 0, prevRst = 0, v;
    logic [15:0] gap = 16'h0;
    logic [3:0]  h = 4'h0;
    logic        watchdog_toggle_in, watchdogFloat, resetOutN, resetOut;
    logic        watchdog_timeout_n, supplyLowN, chipSelOutN;
    int          n_errors = 0, checked = 0, cyc = 0, nFall = 0, div = 0;
    int          lastTgl = 0, tEv = 0, d = 0, i;
    swr_watchdog #(.DIV(DIVS)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .supply_sense_in(supply_sense_in),
        .watchdog_toggle_in(watchdog_toggle_in),
        .watchdogFloat(watchdogFloat),
        .timebase_source_sel(timebase_source_sel),
        .timebase_in(timebase_in), .chipSelInN(chipSelInN),
        .resetOutN(resetOutN), .resetOut(resetOut),
        .watchdog_timeout_n(watchdog_timeout_n), .supplyLowN(supplyLowN),
        .chipSelOutN(chipSelOutN));
    swr_cpu_model i_cpu (
        .clk(clk), .resetOutN(resetOutN), .enable(enable), .gap(gap),
        .floatReq(floatReq), .toggleOut(watchdog_toggle_in),
        .floatOut(watchdogFloat));
    // ==========================================================
    // clock, external timebase and monitors
    // ==========================================================
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (extRun) begin
            div         <= (div == EXTP - 1) ? 0 : div + 1;
            timebase_in <= (div < 3);
        end
    end
    always @(negedge clk) begin
        if (watchdog_toggle_in !== prevTgl) lastTgl = cyc;
        prevTgl = watchdog_toggle_in;
        if (!sys_rst) begin
            `CHK("reset pair", ~resetOutN, resetOut)
            if (prevRst === 1'b1 && resetOutN === 1'b0) nFall++;
        end
        prevRst = resetOutN;
    end
    // ==========================================================
    // helpers
    // ==========================================================
    function int expCyc(input int kind); // 0 reset, 1 short, 2 long
        if (!timebase_source_sel)
            return (kind == 0 ? EXT_RST_TICKS : kind == 1 ?
                    EXT_SHORT_TICKS : EXT_LONG_TICKS) * EXTP;
        return (kind == 0 ? INT_RST_TICKS : (kind == 1 && !timebase_in) ?
                INT_SHORT_TICKS : INT_LONG_TICKS) * DIVS;
    endfunction : expCyc
    task near(input string what, input int dt, input int kind);
        int e;
        e = expCyc(kind);
        // slack covers synchroniser latency and tick phase
        `CHK(what, e, (dt >= e - 3 && dt <= e + 9) ? e : dt)
    endtask : near
    task waitRst(input logic lvl, input int lim);
        for (i = 0; i < lim && resetOutN !== lvl; i++) @(negedge clk);
        `CHK("reset level", lvl, resetOutN)
        tEv = cyc;
    endtask : waitRst
    task nextTgl(input int lim);
        int t, k;
        t = lastTgl;
        for (k = 0; k < lim && lastTgl == t; k++) @(negedge clk);
        `CHK("toggle seen", 1'b1, lastTgl != t)
    endtask : nextTgl
    task results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        results;
    end
    // ==========================================================
    // scenarios
    // ==========================================================
    initial begin
        void'($urandom(32'h1a3f3917));
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("reset at start", 1'b0, resetOutN)
        `CHK("status at start", 1'b1, watchdog_timeout_n)
        @(posedge clk);
        sys_rst <= 0;
        d = cyc;
        waitRst(1'b1, 4000);
        near("ext reset period", tEv - d, 0);
        @(posedge clk);
        gap    <= 16'(1200 * EXTP);
        enable <= 1;
        nextTgl(8000);
        `CHK("falls before first toggle", 0, nFall)
        repeat (5) begin
            @(posedge clk);
            gap <= 16'($urandom_range(4800, 600));
            nextTgl(6000);
        end
        `CHK("falls while serviced", 0, nFall)
        @(posedge clk);
        enable <= 0;
        waitRst(1'b0, 7000);
        near("short timeout", tEv - lastTgl, 1);
        repeat (2) @(negedge clk);
        `CHK("status on timeout", 1'b0, watchdog_timeout_n)
        d = tEv;
        waitRst(1'b1, 4000);
        near("watchdog pulse", tEv - d, 0);
        repeat (100) @(negedge clk);
        `CHK("status holds", 1'b0, watchdog_timeout_n)
        for (int j = 0; j < 40; j++) begin
            @(posedge clk);
            v = 1'($urandom);
            chipSelInN      <= v;
            supply_sense_in <= (j >= 10 && j < 25);
            h = {h[2:0], v};
            if (j == 25) d = cyc;
            @(negedge clk);
            if (j >= 13 && j < 25) begin
                `CHK("reset in low supply", 1'b0, resetOutN)
                `CHK("status in low supply", 1'b1, watchdog_timeout_n)
                `CHK("supply flag low", 1'b0, supplyLowN)
                `CHK("cs blocked", 1'b1, chipSelOutN)
            end else if ((j >= 3 && j < 10) || j >= 28) begin
                `CHK("cs follows", h[3], chipSelOutN)
                `CHK("supply flag high", 1'b1, supplyLowN)
            end
        end
        waitRst(1'b1, 4000);
        near("supply reset period", tEv - d, 0);
        d = tEv;
        waitRst(1'b0, 22000);
        near("long timeout", tEv - d, 2);
        waitRst(1'b1, 4000);
        `CHK("status after repeat", 1'b0, watchdog_timeout_n)
        @(posedge clk);
        gap    <= 16'd50;
        enable <= 1;
        nextTgl(200);
        repeat (4) @(negedge clk);
        `CHK("status cleared", 1'b1, watchdog_timeout_n)
        @(posedge clk);
        enable   <= 0;
        floatReq <= 1;
        d = nFall;
        repeat (1300 * EXTP) @(posedge clk);
        `CHK("falls while floating", d, nFall)
        floatReq <= 0;
        extRun   <= 0;
        @(posedge clk);
        timebase_in         <= 0;
        timebase_source_sel <= 1;
        supply_sense_in     <= 1;
        repeat (6) @(posedge clk);
        supply_sense_in <= 0;
        d = cyc;
        waitRst(1'b1, 4000);
        near("int reset period", tEv - d, 0);
        @(posedge clk);
        gap    <= 16'd100;
        enable <= 1;
        nextTgl(400);
        @(posedge clk);
        enable <= 0;
        waitRst(1'b0, 6000);
        near("int short timeout", tEv - lastTgl, 1);
        d = tEv;
        waitRst(1'b1, 4000);
        near("int pulse", tEv - d, 0);
        @(posedge clk);
        timebase_in <= 1;
        enable      <= 1;
        nextTgl(400);
        @(posedge clk);
        enable <= 0;
        d = nFall;
        repeat (1200 * DIVS) @(posedge clk);
        `CHK("no short period", d, nFall)
        results;
    end
endmodule : test_supervisor_watchdog_reset
